// ===== design/imd_pkg.sv
// What this block does
// - Provide 256 bytes of internal RAM at data addresses 0x00 to 0xFF.
// - Lower 128 RAM bytes are reachable by direct and by indirect access.
// - Bytes 0x00 to 0x1F form four banks of eight working registers.
// - Exactly one bank is active, chosen by status word bits 3 and 4.
// - Indirect accesses take their address from register 0 or 1.
// - Bytes 0x20 to 0x2F are reachable as bytes or as 128 bits.
// - Bit address below 0x80 maps to byte 0x20 plus address/8, bit address%8.
// - Bit or byte access is chosen by operand kind, not by address.
// - Upper 128 RAM bytes are indirect only, separate from special registers.
// - Direct accesses to 0x80 to 0xFF go to special register space.
// - Indirect accesses above 0x7F go to upper RAM.
// - Stack pointer marks last used location; stack may lie anywhere.
// - Push writes at pointer plus one, then increments the pointer.
// - Every reset loads the stack pointer with 0x07.
// - The stack pointer sits at special register address 0x81.
// - Stack may grow to 256 bytes over the full 8-bit pointer range.
// - Special registers at x0 or x8 are bit and byte accessible.
package imd_pkg;
  localparam int RAM_BYTES = 256;
  localparam int UPPER_BIT = 7;
  localparam int BANK_LO_BIT = 3;
  localparam int BANK_HI_BIT = 4;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] STACK_STEP = 8'h01;

  // Operand kinds issued by the execution logic
  typedef enum logic [2:0] {
    K_DIRECT,
    K_INDIRECT,
    K_REG,
    K_BIT,
    K_PUSH,
    K_POP
  } imd_kind_t;
endpackage

// ===== design/imd_decoder.sv
`timescale 1ns/1ps
module imd_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire imd_pkg::imd_kind_t req_kind,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_reg,
  input wire logic req_ri,
  input wire logic [7:0] req_wdata,
  input wire logic req_wbit,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_bit,
  output logic sfr_req,
  output logic sfr_write,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] stack_pointer,
  output logic [7:0] program_status_word
);
  import imd_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_EXT_RD, S_EXT_WB} imd_state_t;

  logic [7:0] ram_q [RAM_BYTES];
  logic [7:0] sp_q;
  logic [7:0] psw_q;
  imd_state_t state_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_rdata_q;
  logic rsp_bit_q;
  logic sfr_req_q;
  logic sfr_write_q;
  logic [7:0] sfr_addr_q;
  logic [7:0] sfr_wdata_q;
  logic [2:0] bitpos_q;
  logic wbit_q;
  logic bitwr_q;

  logic take;
  logic [1:0] bank;
  logic [7:0] ri_addr;
  logic [7:0] ind_addr;
  logic [7:0] push_addr;
  logic [7:0] pop_addr;
  logic [7:0] ea;
  logic [2:0] bitpos;
  logic to_sfr;
  logic is_sp;
  logic is_psw;
  logic ext;
  logic [7:0] rd_byte;
  logic [7:0] mod_byte;
  logic [7:0] wr_byte;
  logic do_wr;
  logic [7:0] ext_mod;

  function automatic logic [7:0] put_bit(input logic [7:0] b,
                                         input logic [2:0] pos,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[pos] = v;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  assign take = req_valid && ready_q;
  assign bank = psw_q[BANK_HI_BIT:BANK_LO_BIT];
  assign ri_addr = {3'b000, bank, 2'b00, req_ri};
  assign ind_addr = ram_q[ri_addr];
  assign push_addr = sp_q + STACK_STEP;
  assign pop_addr = sp_q;

  // Kind picks the width; for direct and bit kinds, address bit 7 also picks the space
  always_comb begin
    ea = req_addr;
    to_sfr = 1'b0;
    bitpos = req_addr[2:0];
    case (req_kind)
      K_DIRECT: begin
        ea = req_addr;
        to_sfr = req_addr[UPPER_BIT];
      end
      K_INDIRECT: begin
        ea = ind_addr;
        to_sfr = 1'b0;
      end
      K_REG: begin
        ea = {3'b000, bank, req_reg};
      end
      K_BIT: begin
        if (req_addr[UPPER_BIT]) begin
          ea = {req_addr[7:3], 3'b000};
          to_sfr = 1'b1;
        end else begin
          ea = BIT_AREA_BASE + {4'h0, req_addr[6:3]};
        end
      end
      K_PUSH: begin
        ea = push_addr;
      end
      K_POP: begin
        ea = pop_addr;
      end
      default: begin
        ea = req_addr;
      end
    endcase
  end

  assign is_sp = to_sfr && (ea == SP_ADDR);
  assign is_psw = to_sfr && (ea == PSW_ADDR);
  assign ext = to_sfr && !is_sp && !is_psw;
  assign rd_byte = is_sp ? sp_q : (is_psw ? psw_q : ram_q[ea]);
  assign mod_byte = put_bit(rd_byte, bitpos, req_wbit);
  assign wr_byte = (req_kind == K_BIT) ? mod_byte : req_wdata;
  assign do_wr = take && !ext && (req_kind == K_PUSH ||
                 (req_write && req_kind != K_POP));
  assign ext_mod = put_bit(sfr_rdata, bitpos_q, wbit_q);

  //////////////////////////////////////////////////////////////////////////
  // Storage

  // Data array has no reset; its contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (do_wr && !to_sfr) begin
      ram_q[ea] <= wr_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sp_q <= SP_RESET;
    end else if (take && req_kind == K_PUSH) begin
      sp_q <= push_addr;
    end else if (take && req_kind == K_POP) begin
      sp_q <= sp_q - STACK_STEP;
    end else if (do_wr && is_sp) begin
      sp_q <= wr_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      psw_q <= PSW_RESET;
    end else if (do_wr && is_psw) begin
      psw_q <= wr_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outer special register bus; bit writes need a read, then a write

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      ready_q <= 1'b1;
      sfr_req_q <= 1'b0;
      sfr_write_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wdata_q <= 8'h00;
      bitpos_q <= 3'h0;
      wbit_q <= 1'b0;
      bitwr_q <= 1'b0;
    end else begin
      sfr_req_q <= 1'b0;
      sfr_write_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (take && ext) begin
            state_q <= S_EXT_RD;
            ready_q <= 1'b0;
            sfr_req_q <= 1'b1;
            sfr_write_q <= req_write && req_kind != K_BIT;
            sfr_addr_q <= ea;
            sfr_wdata_q <= req_wdata;
            bitpos_q <= bitpos;
            wbit_q <= req_wbit;
            bitwr_q <= req_write && req_kind == K_BIT;
          end
        end
        S_EXT_RD: begin
          if (bitwr_q) begin
            state_q <= S_EXT_WB;
            sfr_req_q <= 1'b1;
            sfr_write_q <= 1'b1;
            sfr_wdata_q <= ext_mod;
          end else begin
            state_q <= S_IDLE;
            ready_q <= 1'b1;
          end
        end
        S_EXT_WB: begin
          state_q <= S_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= S_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Response

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
      rsp_bit_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == S_IDLE && take && !ext) begin
        rsp_valid_q <= 1'b1;
        rsp_rdata_q <= rd_byte;
        rsp_bit_q <= rd_byte[bitpos];
      end else if (state_q == S_EXT_RD) begin
        rsp_valid_q <= !bitwr_q;
        rsp_rdata_q <= sfr_rdata;
        rsp_bit_q <= sfr_rdata[bitpos_q];
      end else if (state_q == S_EXT_WB) begin
        rsp_valid_q <= 1'b1;
      end
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_bit = rsp_bit_q;
  assign sfr_req = sfr_req_q;
  assign sfr_write = sfr_write_q;
  assign sfr_addr = sfr_addr_q;
  assign sfr_wdata = sfr_wdata_q;
  assign stack_pointer = sp_q;
  assign program_status_word = psw_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sp_reset_value_a: assert property ($fell(rst) |-> sp_q == SP_RESET)
    else $error("stack pointer not 0x07 after reset");

  push_increments_a: assert property (
    take && req_kind == K_PUSH |=> sp_q == $past(push_addr))
    else $error("push did not increment stack pointer");

  push_stores_a: assert property (
    take && req_kind == K_PUSH |=> ram_q[$past(push_addr)] == $past(req_wdata))
    else $error("push data not at pointer plus one");

  pop_decrements_a: assert property (
    take && req_kind == K_POP |=> sp_q == $past(pop_addr) - STACK_STEP)
    else $error("pop did not decrement stack pointer");

  pop_returns_a: assert property (
    take && req_kind == K_POP |=> rsp_valid_q &&
      rsp_rdata_q == ram_q[$past(pop_addr)])
    else $error("pop returned wrong byte");

  direct_upper_sfr_a: assert property (
    take && req_kind == K_DIRECT && req_addr[UPPER_BIT] &&
      req_addr != SP_ADDR && req_addr != PSW_ADDR
      |=> sfr_req_q && sfr_addr_q == $past(req_addr) ##1 !sfr_req_q)
    else $error("direct upper access missed the register bus");

  indirect_ram_a: assert property (
    take && req_kind == K_INDIRECT && req_write
      |=> !sfr_req_q && ram_q[$past(ind_addr)] == $past(req_wdata))
    else $error("indirect write did not land in RAM");

  bank_register_a: assert property (
    take && req_kind == K_REG && req_write
      |=> ram_q[{3'b000, $past(bank), $past(req_reg)}] == $past(req_wdata))
    else $error("register write landed outside active bank");

  bit_area_a: assert property (
    take && req_kind == K_BIT && !req_addr[UPPER_BIT] && !req_write
      |=> rsp_valid_q && rsp_bit_q ==
        $past(ram_q[BIT_AREA_BASE + {4'h0, req_addr[6:3]}][req_addr[2:0]]))
    else $error("bit read from wrong bit area position");

  ext_bit_rmw_a: assert property (
    take && ext && req_kind == K_BIT && req_write
      |=> sfr_req_q && !sfr_write_q ##1 sfr_req_q && sfr_write_q
      ##1 rsp_valid_q && ready_q)
    else $error("bit write to outer register lacked read then write");

endmodule

// ===== sim/imd_sfr_model.sv
`timescale 1ns/1ps
module imd_sfr_model (
  input wire logic ref_clk,
  input wire logic sfr_req,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs_q [256];
  logic [7:0] junk_q = 8'h00;
  // Preset pattern so reads are predictable before any write
  initial for (int i = 0; i < 256; i++) regs_q[i] = 8'(i) ^ 8'h5a;
  always @(posedge ref_clk) begin
    junk_q <= junk_q + 8'h3b;
    if (sfr_req && sfr_write) regs_q[sfr_addr] <= sfr_wdata;
  end
  // Unselected data churns so a late sample cannot pass by luck
  assign sfr_rdata = sfr_req ? regs_q[sfr_addr] : junk_q;
endmodule

// ===== sim/tb_imd_decoder.sv
`timescale 1ns/1ps
module tb_imd_decoder;
  import imd_pkg::*;
  typedef struct packed {
    logic cd;
    logic [7:0] d;
    logic cb;
    logic b;
  } imd_note_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  imd_kind_t req_kind = K_DIRECT;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [2:0] req_reg = 3'h0;
  logic req_ri = 1'b0;
  logic [7:0] req_wdata = 8'h00;
  logic req_wbit = 1'b0;
  logic req_ready, rsp_valid, rsp_bit, sfr_req, sfr_write;
  logic [7:0] rsp_rdata, sfr_addr, sfr_wdata, sfr_rdata;
  logic [7:0] stack_pointer, program_status_word;
  imd_note_t notes[$];
  imd_note_t n;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 87;
  logic [7:0] v, w;
  imd_note_t x = '0;

  imd_decoder imd_decoder_inst (.ref_clk, .rst, .req_valid, .req_ready,
    .req_kind, .req_write, .req_addr, .req_reg, .req_ri, .req_wdata,
    .req_wbit, .rsp_valid, .rsp_rdata, .rsp_bit, .sfr_req, .sfr_write,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .stack_pointer,
    .program_status_word);
  imd_sfr_model imd_sfr_model_inst (.ref_clk, .sfr_req, .sfr_write,
    .sfr_addr, .sfr_wdata, .sfr_rdata);

  initial forever #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic imd_note_t ex(logic cd, logic [7:0] d, logic cb,
      logic b);
    return '{cd, d, cb, b};
  endfunction

  // Request stays up until an edge that sees ready; a holds reg/ri too
  task automatic op(input imd_kind_t k, input logic wr, input logic [7:0] a,
      input logic [7:0] wd, input imd_note_t e);
    int t;
    logic r;
    req_valid <= 1'b1;
    req_kind <= k;
    req_write <= wr;
    req_addr <= a;
    req_reg <= a[2:0];
    req_ri <= a[0];
    req_wdata <= wd;
    req_wbit <= wd[0];
    notes.push_back(e);
    t = 0;
    do begin
      @(negedge ref_clk);
      r = req_ready;
      @(posedge ref_clk);
      t++;
    end while (r !== 1'b1 && t < 50);
    if (t >= 50) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // Oldest note is matched to each answer
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: answer with nothing pending", $time);
      end else begin
        n = notes.pop_front();
        if (n.cd) chk(rsp_rdata, n.d);
        if (n.cb) chk({7'h0, rsp_bit}, {7'h0, n.b});
      end
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    chk(stack_pointer, SP_RESET);
    v = 8'($random(seed));
    w = 8'($random(seed));
    op(K_DIRECT, 0, SP_ADDR, 8'h00, ex(1, 8'h07, 0, 0));
    op(K_PUSH, 0, 8'h00, v, x);
    op(K_DIRECT, 0, 8'h08, 8'h00, ex(1, v, 0, 0));
    op(K_POP, 0, 8'h00, 8'h00, ex(1, v, 0, 0));
    op(K_DIRECT, 0, SP_ADDR, 8'h00, ex(1, 8'h07, 0, 0));
    for (int b = 0; b < 4; b++) begin
      op(K_DIRECT, 1, PSW_ADDR, 8'(b << 3), x);
      for (int r = 0; r < 8; r++) begin
        w = 8'($random(seed));
        op(K_REG, 1, 8'(r), w, x);
        op(K_DIRECT, 0, 8'(b * 8 + r), 8'h00, ex(1, w, 0, 0));
      end
    end
    op(K_REG, 1, 8'h01, 8'h9c, x);
    op(K_REG, 1, 8'h00, 8'h45, x);
    op(K_INDIRECT, 1, 8'h01, v, x);
    op(K_INDIRECT, 0, 8'h01, 8'h00, ex(1, v, 0, 0));
    op(K_DIRECT, 0, 8'h9c, 8'h00, ex(1, 8'hc6, 0, 0));
    op(K_INDIRECT, 1, 8'h00, w, x);
    op(K_DIRECT, 0, 8'h45, 8'h00, ex(1, w, 0, 0));
    op(K_DIRECT, 1, 8'h22, 8'h00, x);
    op(K_DIRECT, 1, 8'h13, 8'h00, x);
    op(K_DIRECT, 1, 8'h2f, 8'h80, x);
    op(K_BIT, 1, 8'h13, 8'h01, x);
    op(K_DIRECT, 0, 8'h22, 8'h00, ex(1, 8'h08, 0, 0));
    op(K_DIRECT, 0, 8'h13, 8'h00, ex(1, 8'h00, 0, 0));
    op(K_BIT, 0, 8'h7f, 8'h00, ex(0, 8'h00, 1, 1));
    op(K_BIT, 0, 8'h78, 8'h00, ex(0, 8'h00, 1, 0));
    op(K_BIT, 1, 8'h8c, 8'h00, x);
    op(K_DIRECT, 0, 8'h88, 8'h00, ex(1, 8'hc2, 0, 0));
    op(K_DIRECT, 1, 8'h88, v, x);
    op(K_BIT, 0, 8'h8b, 8'h00, ex(1, v, 1, v[3]));
    op(K_BIT, 0, 8'hd3, 8'h00, ex(0, 8'h00, 1, 1));
    // Stack moved to top of memory; the second push wraps the pointer into register byte 0x00
    op(K_DIRECT, 1, SP_ADDR, 8'hfe, x);
    op(K_PUSH, 0, 8'h00, v, x);
    op(K_PUSH, 0, 8'h00, w, x);
    op(K_DIRECT, 0, SP_ADDR, 8'h00, ex(1, 8'h00, 0, 0));
    op(K_DIRECT, 0, 8'h00, 8'h00, ex(1, w, 0, 0));
    op(K_POP, 0, 8'h00, 8'h00, ex(1, w, 0, 0));
    op(K_POP, 0, 8'h00, 8'h00, ex(1, v, 0, 0));
    req_valid <= 1'b0;
    for (int t = 0; t < 20 && notes.size() > 0; t++) @(posedge ref_clk);
    @(posedge ref_clk);
    if (notes.size() > 0) mismatches++;
    chk(stack_pointer, 8'hfe);
    chk(program_status_word, 8'h18);
    chk({7'h0, req_ready}, 8'h01);
    give_verdict();
  end
endmodule
